// ---- hw/wdtrl_pkg.sv ----
// package: register map, field positions, reset values and types of the watchdog block
package wdtrl_pkg;

   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_UPPER   = 8'h04;
   localparam logic [7:0] OFF_HIGH    = 8'h08;
   localparam logic [7:0] OFF_LOW     = 8'h0C;
   localparam logic [7:0] OFF_REFRESH = 8'h10;
   localparam logic [7:0] OFF_CFG     = 8'h14;
   localparam logic [7:0] OFF_COUNT   = 8'h18;
   localparam logic [7:0] OFF_ISTAT   = 8'h1C;
   localparam logic [7:0] OFF_ICLR    = 8'h20;
   localparam logic [7:0] OFF_IEN     = 8'h24;

   // ***************************************************************
   // fields
   // ***************************************************************
   localparam int CTRL_TO_BIT   = 0;
   localparam int CTRL_STOP_BIT = 1;
   localparam int CTRL_LOCK_BIT = 2;
   localparam int CFG_EN_BIT    = 0;
   localparam int CFG_RST_BIT   = 1;
   localparam int IRQ_NUM       = 3;
   localparam int IRQ_TIMEOUT   = 0;
   localparam int IRQ_RESET     = 1;
   localparam int IRQ_LOCKERR   = 2;

   // ***************************************************************
   // unlock keys and reset values
   // ***************************************************************
   localparam logic [7:0]  KEY_FIRST  = 8'h55;
   localparam logic [7:0]  KEY_SECOND = 8'hAA;
   localparam logic [23:0] RELOAD_RST = 24'hFF_FFFF;
   localparam logic [1:0]  CFG_RST    = 2'h0;
   localparam logic [2:0]  IEN_RST    = 3'h0;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [2:0] {
      TGT_CTRL  = 3'b000,
      TGT_UPPER = 3'b001,
      TGT_HIGH  = 3'b010,
      TGT_LOW   = 3'b011,
      TGT_OTHER = 3'b100
   } wdtrl_target_t;

   typedef enum logic [2:0] {
      LK_LOCKED = 3'b000,
      LK_KEY1   = 3'b001,
      LK_OPEN   = 3'b010,
      LK_GOTU   = 3'b011,
      LK_GOTH   = 3'b100
   } wdtrl_lkst_t;

   typedef struct packed {
      logic          valid;
      wdtrl_target_t target;
      logic [7:0]    data;
   } wdtrl_wr_t;

   typedef struct packed {
      logic accUpper;
      logic accHigh;
      logic accLow;
      logic keyWrite;
      logic violation;
      logic locked;
   } wdtrl_lockres_t;

endpackage

// ---- hw/wdtrl_lock.sv ----
// module: lock state machine that guards the three reload byte registers
module wdtrl_lock (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire wdtrl_pkg::wdtrl_wr_t     wrEv,
   output wdtrl_pkg::wdtrl_lockres_t     res
);
   import wdtrl_pkg::*;

   wdtrl_lkst_t state_q;
   wdtrl_lkst_t state_d;

   wire isCtrl  = wrEv.valid && (wrEv.target == TGT_CTRL);
   wire isKey1  = isCtrl && (wrEv.data == KEY_FIRST);
   wire isKey2  = isCtrl && (wrEv.data == KEY_SECOND);
   wire isUpper = wrEv.valid && (wrEv.target == TGT_UPPER);
   wire isHigh  = wrEv.valid && (wrEv.target == TGT_HIGH);
   wire isLow   = wrEv.valid && (wrEv.target == TGT_LOW);

   always_comb begin
      state_d = state_q;
      if (wrEv.valid) begin
         case (state_q)
            LK_LOCKED: state_d = isKey1 ? LK_KEY1 : LK_LOCKED;
            LK_KEY1:   state_d = isKey2 ? LK_OPEN : (isKey1 ? LK_KEY1 : LK_LOCKED);
            LK_OPEN:   state_d = isUpper ? LK_GOTU : (isKey1 ? LK_KEY1 : LK_LOCKED);
            LK_GOTU:   state_d = isHigh ? LK_GOTH : (isKey1 ? LK_KEY1 : LK_LOCKED);
            LK_GOTH:   state_d = isKey1 ? LK_KEY1 : LK_LOCKED;
            default:   state_d = LK_LOCKED;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) state_q <= LK_LOCKED;
      else        state_q <= state_d;
   end

   // reload bytes pass only in their own step of the sequence
   assign res.accUpper  = isUpper && (state_q == LK_OPEN);
   assign res.accHigh   = isHigh && (state_q == LK_GOTU);
   assign res.accLow    = isLow && (state_q == LK_GOTH);
   assign res.keyWrite  = isKey1 || isKey2;
   assign res.violation = wrEv.valid && (state_q != LK_LOCKED) && (state_q != LK_GOTH)
                          && (state_d == LK_LOCKED);
   assign res.locked    = (state_q == LK_LOCKED);

endmodule // wdtrl_lock

// ---- hw/wdtrl_top.sv ----
// module: watchdog time-out reset path, reload lock and AHB-Lite register slave
// ***************************************************************
// notes
// ***************************************************************
// Functional notes
// - time-out with reset option in normal run requests system reset
// - such a reset sets the time-out flag in the control register
// - time-out with reset option in stop mode starts stop recovery
// - stop-mode time-out with reset option sets time-out flag and stop flag
// - key writes leave the time-out and stop flag bits unchanged; the lock bit follows the sequence state
// - any other write mid-sequence relocks, except a first-key write, which restarts the sequence; software must restart
// - reload byte writes are ignored unless sequence unlocked them
// - reload value loads into counter on first enable and each refresh while enabled
// - time-out resets only with reset option set, else raises interrupt
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
module wdtrl_top (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        stopMode,
   output logic             sysResetReq,
   output logic             stopRecovery,
   output logic             irq
);
   import wdtrl_pkg::*;

   // ***************************************************************
   // address phase capture
   // ***************************************************************
   logic [7:0]  addr_q;
   logic        wrPend_q;
   logic        rdPend_q;
   logic [31:0] rdata_q;
   logic        ready_q;

   wire addrPhase = hsel && htrans[1] && hready;
   wire inRange   = (haddr[31:8] == 24'h00_0000);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_q   <= 8'h00;
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
      end else begin
         if (addrPhase) addr_q <= inRange ? haddr[7:0] : 8'hFF;
         wrPend_q <= addrPhase && hwrite;
         rdPend_q <= addrPhase && !hwrite;
      end
   end

   wire [7:0] wByte  = hwdata[7:0];
   wire       wrCtrl = wrPend_q && (addr_q == OFF_CTRL);
   wire       wrUp   = wrPend_q && (addr_q == OFF_UPPER);
   wire       wrHi   = wrPend_q && (addr_q == OFF_HIGH);
   wire       wrLo   = wrPend_q && (addr_q == OFF_LOW);
   wire       wrRef  = wrPend_q && (addr_q == OFF_REFRESH);
   wire       wrCfg  = wrPend_q && (addr_q == OFF_CFG);
   wire       wrIclr = wrPend_q && (addr_q == OFF_ICLR);
   wire       wrIen  = wrPend_q && (addr_q == OFF_IEN);

   // ***************************************************************
   // lock sequence
   // ***************************************************************
   wdtrl_wr_t      wrEv;
   wdtrl_lockres_t lockRes;

   assign wrEv.valid  = wrPend_q;
   assign wrEv.data   = wByte;
   assign wrEv.target = wrCtrl ? TGT_CTRL  :
                        wrUp   ? TGT_UPPER :
                        wrHi   ? TGT_HIGH  :
                        wrLo   ? TGT_LOW   : TGT_OTHER;

   wdtrl_lock uLock (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wrEv    (wrEv),
      .res     (lockRes)
   );

   // ***************************************************************
   // reload bytes and configuration
   // ***************************************************************
   logic [23:0] reload_q;
   logic [1:0]  cfg_q;
   logic        enPrev_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reload_q <= RELOAD_RST;
         cfg_q    <= CFG_RST;
         enPrev_q <= 1'b0;
      end else begin
         if (lockRes.accUpper) reload_q[23:16] <= wByte;
         if (lockRes.accHigh)  reload_q[15:8]  <= wByte;
         if (lockRes.accLow)   reload_q[7:0]   <= wByte;
         if (wrCfg)            cfg_q           <= wByte[1:0];
         enPrev_q <= cfg_q[CFG_EN_BIT];
      end
   end

   wire enabled   = cfg_q[CFG_EN_BIT];
   wire rstOption = cfg_q[CFG_RST_BIT];
   wire firstEn   = enabled && !enPrev_q;

   // ***************************************************************
   // counter and time-out
   // ***************************************************************
   logic [23:0] count_q;
   logic [23:0] count_d;

   wire timeout = enabled && !firstEn && !wrRef && (count_q == 24'h00_0000);
   wire loadCnt = firstEn || (enabled && wrRef) || timeout;

   assign count_d = loadCnt ? reload_q : (enabled ? count_q - 24'h00_0001 : count_q);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) count_q <= RELOAD_RST;
      else        count_q <= count_d;
   end

   wire toReset = timeout && rstOption && !stopMode;
   wire toStop  = timeout && rstOption && stopMode;
   wire toIrq   = timeout && !rstOption;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sysResetReq  <= 1'b0;
         stopRecovery <= 1'b0;
      end else begin
         sysResetReq  <= toReset;
         stopRecovery <= toStop;
      end
   end

   // ***************************************************************
   // control register flags
   // ***************************************************************
   logic toFlag_q;
   logic stopFlag_q;

   // other values clear flags written as one; key values touch nothing
   wire ctrlClr  = wrCtrl && !lockRes.keyWrite;
   wire toSet    = toReset || toStop;
   wire toClr    = ctrlClr && wByte[CTRL_TO_BIT];
   wire stopClr  = ctrlClr && wByte[CTRL_STOP_BIT];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         toFlag_q   <= 1'b0;
         stopFlag_q <= 1'b0;
      end else begin
         toFlag_q   <= toSet || (toFlag_q && !toClr);
         stopFlag_q <= toStop || (stopFlag_q && !stopClr);
      end
   end

   // ***************************************************************
   // interrupt status, clear and enable
   // ***************************************************************
   logic [IRQ_NUM-1:0] istat_q;
   logic [IRQ_NUM-1:0] ien_q;
   logic [IRQ_NUM-1:0] iev;
   logic               irq_q;

   assign iev[IRQ_TIMEOUT] = toIrq;
   assign iev[IRQ_RESET]   = toSet;
   assign iev[IRQ_LOCKERR] = lockRes.violation;

   genvar gi;
   generate
      for (gi = 0; gi < IRQ_NUM; gi++) begin : gIrq
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) istat_q[gi] <= 1'b0;
            else        istat_q[gi] <= iev[gi] || (istat_q[gi] && !(wrIclr && hwdata[gi]));
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ien_q <= IEN_RST;
         irq_q <= 1'b0;
      end else begin
         if (wrIen) ien_q <= hwdata[IRQ_NUM-1:0];
         irq_q <= |(istat_q & ien_q);
      end
   end

   assign irq = irq_q;

   // ***************************************************************
   // read path: one wait state so a preceding write is always seen
   // ***************************************************************
   logic [31:0] rmux;

   always_comb begin
      rmux = 32'h0000_0000;
      case (addr_q)
         OFF_CTRL: begin
            rmux[CTRL_TO_BIT]   = toFlag_q;
            rmux[CTRL_STOP_BIT] = stopFlag_q;
            rmux[CTRL_LOCK_BIT] = lockRes.locked;
         end
         OFF_UPPER: rmux[7:0]          = reload_q[23:16];
         OFF_HIGH:  rmux[7:0]          = reload_q[15:8];
         OFF_LOW:   rmux[7:0]          = reload_q[7:0];
         OFF_CFG:   rmux[1:0]          = cfg_q;
         OFF_COUNT: rmux[23:0]         = count_q;
         OFF_ISTAT: rmux[IRQ_NUM-1:0]  = istat_q;
         OFF_IEN:   rmux[IRQ_NUM-1:0]  = ien_q;
         default:   rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b1;
      end else begin
         if (rdPend_q) rdata_q <= rmux;
         ready_q <= !(addrPhase && !hwrite);
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = ready_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) hresp <= 1'b0;
      else        hresp <= 1'b0;
   end

endmodule // wdtrl_top

// ---- sim/wdtrl_monitor.sv ----
// checker: bus handshake and reset-path pulse properties of the watchdog block
module wdtrl_monitor (
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       stopMode,
   input wire logic       sysResetReq,
   input wire logic       stopRecovery,
   input wire logic       irq
);
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic rdReq = hsel && htrans[1] && hready && !hwrite;
   wire logic wrReq = hsel && htrans[1] && hready && hwrite;

   chk_rst_pulse: assert property (sysResetReq |=> !sysResetReq)
      else $error("reset request longer than one cycle");
   chk_rst_normal: assert property (sysResetReq |-> !$past(stopMode) && !stopRecovery)
      else $error("reset request during stop mode");
   chk_stop_pulse: assert property (stopRecovery |=> !stopRecovery)
      else $error("stop recovery longer than one cycle");
   chk_stop_mode: assert property (stopRecovery |-> $past(stopMode))
      else $error("stop recovery outside stop mode");
   chk_quiet_release: assert property ($rose(rst_n) |-> !sysResetReq && !stopRecovery && !irq)
      else $error("outputs active at reset release");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_read_wait: assert property (rdReq |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (wrReq |=> hreadyout)
      else $error("write inserted wait state");
   cover property (sysResetReq);
   cover property (stopRecovery);
   cover property (rdReq ##2 hreadyout);
endmodule // wdtrl_monitor

// ---- sim/tb_watchdog_reset_and_reload_lock.sv ----
// testbench: register bus, unlock sequence and time-out scenarios of the watchdog block
module tb_watchdog_reset_and_reload_lock;
   timeunit 1ns;
   timeprecision 1ps;
   import wdtrl_pkg::*;
   // ***************************************************************
   // signals and design
   // ***************************************************************
   localparam logic [7:0] RLD = 8'h10;
   logic        clk_sys  = 1'b0;
   logic        rst_n    = 1'b0;
   logic        hsel     = 1'b0;
   logic [31:0] haddr    = 32'h0000_0000;
   logic [1:0]  htrans   = 2'h0;
   logic        hwrite   = 1'b0;
   logic [31:0] hwdata   = 32'h0000_0000;
   logic        stopMode = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        sysResetReq;
   logic        stopRecovery;
   logic        irq;
   logic [31:0] rd;
   int          n;
   int          error_cnt = 0;
   int          checks = 0;
   always #5 clk_sys = ~clk_sys;
   wdtrl_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stopMode(stopMode),
      .sysResetReq(sysResetReq), .stopRecovery(stopRecovery), .irq(irq));
   // ***************************************************************
   // bus and check tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic waitReady();
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
   endtask
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      waitReady();
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer({24'h0, a}, 1'b1, {24'h0, d});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      xfer({24'h0, a}, 1'b0, 32'h0000_0000);
      check(rd & m, e);
   endtask
   task automatic load(input logic [7:0] u, input logic [7:0] h, input logic [7:0] l);
      wr(OFF_CTRL, KEY_FIRST);
      wr(OFF_CTRL, KEY_SECOND);
      wr(OFF_UPPER, u);
      wr(OFF_HIGH, h);
      wr(OFF_LOW, l);
   endtask
   task automatic waitPulse(input logic stopSel);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((stopSel ? stopRecovery : sysResetReq) !== 1'b1 && n < 200);
   endtask
   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic sResetLocked();
      rdc(OFF_CTRL, 32'h7, 32'h4);
      rdc(OFF_COUNT, 32'hFF_FFFF, {8'h0, RELOAD_RST});
      rdc(OFF_UPPER, 32'hFF, {24'h0, RELOAD_RST[23:16]});
      rdc(OFF_HIGH, 32'hFF, {24'h0, RELOAD_RST[15:8]});
      rdc(OFF_CFG, 32'h3, {30'h0, CFG_RST});
      rdc(OFF_IEN, 32'h7, {29'h0, IEN_RST});
      xfer(32'h0000_0200, 1'b0, 32'h0);
      check(rd, 32'h0);
      wr(OFF_UPPER, 8'h12);
      wr(OFF_LOW, 8'h34);
      rdc(OFF_UPPER, 32'hFF, 32'hFF);
      rdc(OFF_LOW, 32'hFF, 32'hFF);
   endtask
   task automatic sSequence();
      wr(OFF_CTRL, KEY_FIRST);
      rdc(OFF_CTRL, 32'h3, 32'h0);
      wr(OFF_CTRL, KEY_SECOND);
      rdc(OFF_CTRL, 32'h7, 32'h0);
      wr(OFF_UPPER, 8'h00);
      wr(OFF_HIGH, 8'h00);
      wr(OFF_LOW, RLD);
      rdc(OFF_CTRL, 32'h4, 32'h4);
      rdc(OFF_LOW, 32'hFF, {24'h0, RLD});
      wr(OFF_LOW, 8'h20);
      rdc(OFF_LOW, 32'hFF, {24'h0, RLD});
      wr(OFF_CTRL, KEY_FIRST);
      wr(OFF_CTRL, KEY_SECOND);
      wr(OFF_UPPER, 8'h01);
      wr(OFF_IEN, 8'h00);
      wr(OFF_HIGH, 8'h33);
      rdc(OFF_UPPER, 32'hFF, 32'h01);
      rdc(OFF_HIGH, 32'hFF, 32'h00);
      rdc(OFF_ISTAT, 32'h4, 32'h4);
      wr(OFF_ICLR, 8'h04);
      load(8'h00, 8'h00, RLD);
   endtask
   task automatic sTimeout(input logic stopSel);
      stopMode <= stopSel;
      wr(OFF_IEN, 8'h02);
      wr(OFF_CFG, 8'h03);
      waitPulse(stopSel);
      check(32'(n), 32'(RLD) + 32'h3);
      waitPulse(stopSel);
      check(32'(n), 32'(RLD) + 32'h1);
      @(posedge clk_sys);
      wr(OFF_CFG, 8'h00);
      rdc(OFF_CTRL, 32'h3, {30'h0, stopSel, 1'b1});
      check({31'h0, irq}, 32'h1);
      stopMode <= 1'b0;
      wr(OFF_CTRL, KEY_FIRST);
      rdc(OFF_CTRL, 32'h3, {30'h0, stopSel, 1'b1});
      wr(OFF_CTRL, 8'h03);
      rdc(OFF_ISTAT, 32'h4, 32'h4);
      wr(OFF_ICLR, 8'h07);
      rdc(OFF_CTRL, 32'h3, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask
   task automatic sIrqOnly();
      wr(OFF_IEN, 8'h00);
      wr(OFF_CFG, 8'h01);
      repeat (12) wr(OFF_REFRESH, 8'h00);
      rdc(OFF_ISTAT, 32'h1, 32'h0);
      repeat (24) @(posedge clk_sys);
      rdc(OFF_ISTAT, 32'h3, 32'h1);
      check({31'h0, irq}, 32'h0);
      wr(OFF_IEN, 8'h01);
      rdc(OFF_IEN, 32'h7, 32'h1);
      check({31'h0, irq}, 32'h1);
      wr(OFF_CFG, 8'h00);
      wr(OFF_ICLR, 8'h01);
      rdc(OFF_ISTAT, 32'h1, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask
   // ***************************************************************
   // run control
   // ***************************************************************
   task automatic complete_run();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      sResetLocked();
      sSequence();
      sTimeout(1'b0);
      sTimeout(1'b1);
      sIrqOnly();
      complete_run();
   end
   initial begin
      #100us;
      error_cnt++;
      complete_run();
   end
endmodule // tb_watchdog_reset_and_reload_lock

bind wdtrl_top wdtrl_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .stopMode(stopMode), .sysResetReq(sysResetReq), .stopRecovery(stopRecovery), .irq(irq));
